// ### sepr_defs.vh
// Constants for the serial EEPROM access sequencer: commands, status layout,
// protection levels, timing. Assumes a 40 MHz system clock samples the link.
//
// Operation
// - Status update starts on select rising after command plus eight status bits.
// - Status update abandoned if a seventeenth clock comes before select rises.
// - Protected block stays readable; writes into it are refused.
// - Read is command byte then address byte; command bit 3 is top address bit.
// - Read data goes out MSB first, changing on falling serial clock.
// - Read address advances per byte and wraps to zero after the top.
// - Read ends only on deselect, at any bit; output then released.
// - Read during a program cycle is rejected until deselect.
// - After latch set, latch clear or status read, input ignored until deselect.
// - Byte write needs deselect right after eighth data bit, else cancelled.
// - Correct deselect starts program cycle; busy flag one throughout.
// - End of program cycle clears the write enable latch.
// - Status reads work during array programming with valid flags.
// - One cycle programs one to sixteen bytes of one page.
// - Page loading wraps low four address bits; later byte replaces earlier.
// - Program starts only if select rises after a whole number of bytes.
// - After reset: deselected, idle, latch clear, protection bits kept.
// - Array commands during programming are ignored; cycle runs on.
// - Write-protect pin low clears the write enable latch.
// - Select rising at an invalid point ends the frame and starts no program cycle.
// - Array starts all FFh, protection bits start at 00.
// - Command codes: latch set 06, clear 04, status read 05, status write 01.
// - Status byte shows busy flag and latch flag, both read only.
// - Protection 00 none, 01 upper quarter, 10 upper half, 11 all.
// - Input sampled on rising serial clock, output changed on falling.
`ifndef SEPR_DEFS_VH
`define SEPR_DEFS_VH
`define SEPR_CMD_LATCH_SET 8'h06
`define SEPR_CMD_LATCH_CLR 8'h04
`define SEPR_CMD_STAT_RD 8'h05
`define SEPR_CMD_STAT_WR 8'h01
`define SEPR_OP_READ 3'h3
`define SEPR_OP_WRITE 3'h2
`define SEPR_ERASED 8'hff
`define SEPR_PROT_RESET 2'h0
`define SEPR_PROT_NONE 2'h0
`define SEPR_PROT_QUARTER 2'h1
`define SEPR_PROT_HALF 2'h2
`define SEPR_QUARTER_BASE 9'h180
`define SEPR_HALF_BASE 9'h100
`define SEPR_CLK_PERIOD_NS 25
`define SEPR_PROG_TIME_NS 5000
`endif

// ### sepr_sequencer.v
// Device-side command sequencer of a 512-byte serial EEPROM on a 4-wire link.
// Assumes the link pins are asynchronous to i_clk and the link clock is well
// below a quarter of i_clk, so every serial edge is seen after synchronisation.
`timescale 1ns/1ps
`default_nettype none
`include "sepr_defs.vh"
module sepr_sequencer #(
  parameter ADDR_W = 9,
  parameter PAGE_BYTES = 16,
  parameter PROG_CYC = (`SEPR_PROG_TIME_NS + `SEPR_CLK_PERIOD_NS - 1) / `SEPR_CLK_PERIOD_NS
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_sel_b,
  input wire i_sclk,
  input wire i_sdi,
  input wire i_wp_b,
  output reg o_sdo,
  output reg o_sdo_oe,
  output reg o_busy,
  output reg o_latch,
  output reg [1:0] o_protect
);
  // ****************************************
  // Protocol states
  // ****************************************
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_CMD = 4'h1;
  localparam [3:0] ST_ADDR = 4'h2;
  localparam [3:0] ST_RDATA = 4'h3;
  localparam [3:0] ST_SREAD = 4'h4;
  localparam [3:0] ST_SWDATA = 4'h5;
  localparam [3:0] ST_SWDONE = 4'h6;
  localparam [3:0] ST_WDATA = 4'h7;
  localparam [3:0] ST_WAIT = 4'h8;
  localparam DEPTH = 1 << ADDR_W;
  localparam [15:0] PROG_LEN = PROG_CYC[15:0];

  // ****************************************
  // Storage
  // ****************************************
  reg [7:0] mem [0:DEPTH-1];
  reg [7:0] page_q [0:PAGE_BYTES-1];
  integer k;
  // Power-on image of the array; no reset touches it
  initial begin
    for (k = 0; k < DEPTH; k = k + 1) begin
      mem[k] = `SEPR_ERASED;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Two flops on every pin; edges are found from the second flop only
  reg [1:0] sel_sy_q;
  reg [1:0] clk_sy_q;
  reg [1:0] sdi_sy_q;
  reg [1:0] wp_sy_q;
  reg sel_prev_q;
  reg clk_prev_q;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel_sy_q <= 2'h3;
      clk_sy_q <= 2'h0;
      sdi_sy_q <= 2'h0;
      wp_sy_q <= 2'h3;
      sel_prev_q <= 1'b1;
      clk_prev_q <= 1'b0;
    end else begin
      sel_sy_q <= {sel_sy_q[0], i_sel_b};
      clk_sy_q <= {clk_sy_q[0], i_sclk};
      sdi_sy_q <= {sdi_sy_q[0], i_sdi};
      wp_sy_q <= {wp_sy_q[0], i_wp_b};
      sel_prev_q <= sel_sy_q[1];
      clk_prev_q <= clk_sy_q[1];
    end
  end
  wire sel_b = sel_sy_q[1];
  wire sdi = sdi_sy_q[1];
  wire wp_low = ~wp_sy_q[1];
  wire sel_fall = sel_prev_q & ~sel_b;
  wire sel_rise = ~sel_prev_q & sel_b;
  // Idle clock level is irrelevant: only edges while selected count
  wire clk_rise = ~sel_b & ~sel_prev_q & clk_sy_q[1] & ~clk_prev_q;
  wire clk_fall = ~sel_b & ~sel_prev_q & ~clk_sy_q[1] & clk_prev_q;

  // ****************************************
  // Sequencer registers
  // ****************************************
  reg [3:0] state_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] cmd_q;
  reg [ADDR_W-1:0] addr_q;
  reg [7:0] osr_q;
  reg [2:0] obit_q;
  reg loaded_q;
  reg [PAGE_BYTES-1:0] mask_q;
  reg wel_q;
  reg busy_q;
  reg prog_sr_q;
  reg [15:0] prog_cnt_q;
  reg [1:0] new_prot_q;
  reg [1:0] prot_q;
  reg [ADDR_W-5:0] page_base_q;
  initial prot_q = `SEPR_PROT_RESET;

  // ****************************************
  // Status byte and address arithmetic
  // ****************************************
  wire [7:0] byte_in = {sh_q[6:0], sdi};
  wire [7:0] status = {4'h0, prot_q, wel_q, busy_q};
  wire [ADDR_W-1:0] rd_addr = {cmd_q[3], byte_in};
  wire [ADDR_W-1:0] next_addr = addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire is_read = (cmd_q[7:4] == 4'h0) && (cmd_q[2:0] == `SEPR_OP_READ);

  // ****************************************
  // Block protection
  // ****************************************
  // Whole page shares one protection answer, since block bounds are page aligned
  reg prot_hit;
  always @* begin
    case (prot_q)
      `SEPR_PROT_NONE: prot_hit = 1'b0;
      `SEPR_PROT_QUARTER: prot_hit = (addr_q >= `SEPR_QUARTER_BASE);
      `SEPR_PROT_HALF: prot_hit = (addr_q >= `SEPR_HALF_BASE);
      default: prot_hit = 1'b1;
    endcase
  end

  // ****************************************
  // Program launch conditions
  // ****************************************
  wire arr_go = (state_q == ST_WDATA) && loaded_q && (bit_q == 3'h0)
    && wel_q && !prot_hit;
  // Status update needs exactly the eight status bits, nothing more
  wire sr_go = (state_q == ST_SWDONE) && wel_q;

  // ****************************************
  // Protocol engine
  // ****************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      addr_q <= {ADDR_W{1'b0}};
      osr_q <= 8'h00;
      obit_q <= 3'h0;
      loaded_q <= 1'b0;
      mask_q <= {PAGE_BYTES{1'b0}};
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      prog_sr_q <= 1'b0;
      prog_cnt_q <= 16'h0000;
      new_prot_q <= 2'h0;
      page_base_q <= {(ADDR_W-4){1'b0}};
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else begin
      // Program cycle timer; commands cannot disturb it
      if (busy_q) begin
        // One page slot per cycle, so the program time must cover a whole page
        if (!prog_sr_q && prog_cnt_q < PAGE_BYTES && mask_q[prog_cnt_q[3:0]]) begin
          mem[{page_base_q, prog_cnt_q[3:0]}] <= page_q[prog_cnt_q[3:0]];
        end
        if (prog_cnt_q == PROG_LEN - 16'h0001) begin
          busy_q <= 1'b0;
          wel_q <= 1'b0;
          if (prog_sr_q) begin
            prot_q <= new_prot_q;
          end
        end
        prog_cnt_q <= prog_cnt_q + 16'h0001;
      end
      if (sel_rise) begin
        // Deselect: release output, maybe launch a program cycle
        o_sdo_oe <= 1'b0;
        state_q <= ST_IDLE;
        if (!busy_q && (arr_go || sr_go)) begin
          busy_q <= 1'b1;
          prog_sr_q <= sr_go;
          prog_cnt_q <= 16'h0000;
        end
      end else if (sel_fall) begin
        // A fresh frame always starts with a command byte
        state_q <= ST_CMD;
        bit_q <= 3'h0;
        loaded_q <= 1'b0;
        obit_q <= 3'h0;
      end else if (clk_rise) begin
        sh_q <= byte_in;
        bit_q <= bit_q + 3'h1;
        case (state_q)
          ST_CMD: begin
            if (bit_q == 3'h7) begin
              cmd_q <= byte_in;
              if (byte_in == `SEPR_CMD_LATCH_SET) begin
                wel_q <= 1'b1;
                state_q <= ST_WAIT;
              end else if (byte_in == `SEPR_CMD_LATCH_CLR) begin
                wel_q <= 1'b0;
                state_q <= ST_WAIT;
              end else if (byte_in == `SEPR_CMD_STAT_RD) begin
                osr_q <= status;
                state_q <= ST_SREAD;
              end else if (busy_q) begin
                state_q <= ST_WAIT;
              end else if (byte_in == `SEPR_CMD_STAT_WR) begin
                state_q <= ST_SWDATA;
              end else if (byte_in[7:4] == 4'h0 && (byte_in[2:0] == `SEPR_OP_READ ||
                  byte_in[2:0] == `SEPR_OP_WRITE)) begin
                state_q <= ST_ADDR;
              end else begin
                state_q <= ST_WAIT;
              end
            end
          end
          ST_ADDR: begin
            if (bit_q == 3'h7) begin
              addr_q <= rd_addr;
              if (is_read) begin
                osr_q <= mem[rd_addr];
                state_q <= ST_RDATA;
              end else begin
                // Every write frame starts with an empty page buffer
                mask_q <= {PAGE_BYTES{1'b0}};
                page_base_q <= rd_addr[ADDR_W-1:4];
                state_q <= ST_WDATA;
              end
            end
          end
          ST_SWDATA: begin
            if (bit_q == 3'h7) begin
              new_prot_q <= byte_in[3:2];
              state_q <= ST_SWDONE;
            end
          end
          ST_SWDONE: begin
            // A seventeenth clock abandons the pending status update
            state_q <= ST_WAIT;
          end
          ST_WDATA: begin
            // A byte counts only once its eighth bit is in
            if (bit_q == 3'h7) begin
              page_q[addr_q[3:0]] <= byte_in;
              mask_q[addr_q[3:0]] <= 1'b1;
              addr_q[3:0] <= addr_q[3:0] + 4'h1;
              loaded_q <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end else if (clk_fall) begin
        // Status read reloads the status after each byte, so it repeats
        if (state_q == ST_RDATA || state_q == ST_SREAD) begin
          o_sdo <= osr_q[7];
          o_sdo_oe <= 1'b1;
          obit_q <= obit_q + 3'h1;
          if (obit_q == 3'h7) begin
            if (state_q == ST_RDATA) begin
              addr_q <= next_addr;
              osr_q <= mem[next_addr];
            end else begin
              osr_q <= status;
            end
          end else begin
            osr_q <= {osr_q[6:0], 1'b0};
          end
        end
      end
      // Last in the process, so a low write-protect pin wins over a latch set
      if (wp_low) begin
        wel_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Flag outputs
  // ****************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_busy <= 1'b0;
      o_latch <= 1'b0;
    end else begin
      o_busy <= busy_q;
      o_latch <= wel_q;
    end
  end

  // ****************************************
  // Protection bits output
  // ****************************************
  // No reset: the bits are nonvolatile, so a reset must not make them read 00
  always @(posedge i_clk) begin
    o_protect <= prot_q;
  end
endmodule
`default_nettype wire

// ### sepr_chk.sv
// Port checker for the access sequencer.
// Assumes a bind into sepr_sequencer that hands on its PROG_CYC.
`timescale 1ns/1ps
`default_nettype none
module sepr_chk #(
  parameter PROG_CYC = 200
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_sel_b,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_wp_b,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  input wire logic o_busy,
  input wire logic o_latch,
  input wire logic [1:0] o_protect
);
  logic [15:0] busy_cnt_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Counter instead of a long repetition, which the tools would unroll
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) busy_cnt_q <= 16'h0000;
    else if (o_busy) busy_cnt_q <= busy_cnt_q + 16'h0001;
    else busy_cnt_q <= 16'h0000;
  end
  chk_oe_released: assert property (i_sel_b [*5] |-> !o_sdo_oe)
    else $error("sdo driven while deselected");
  chk_busy_length: assert property ($fell(o_busy) |-> busy_cnt_q == PROG_CYC)
    else $error("program cycle length wrong");
  chk_latch_cleared: assert property ($fell(o_busy) |-> ##[0:1] !o_latch)
    else $error("latch kept after program cycle");
  // Pin sync, latch clear and output flop take four edges after the pin falls
  chk_wp_clears: assert property (!i_wp_b [*5] |-> !o_latch)
    else $error("latch set while write protect low");
  chk_start_on_desel: assert property ($rose(o_busy) |-> i_sel_b && $past(i_sel_b, 2))
    else $error("program started while selected");
  chk_prot_at_end: assert property ($changed(o_protect) |-> $past(o_busy) || $past(o_busy, 2))
    else $error("protect bits changed outside a cycle");
  chk_sdo_after_fall: assert property (o_sdo_oe && $past(o_sdo_oe) && $changed(o_sdo) |-> !$past(i_sclk, 3))
    else $error("sdo changed without clock fall");
  chk_no_restart: assert property ($fell(o_busy) |-> !o_busy [*8])
    else $error("program cycle restarted");
endmodule
`default_nettype wire

// ### sepr_host.sv
// SPI host model in mode 0, one link bit per 8 cycles of i_clk.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
`default_nettype none
module sepr_host (
  input wire logic i_clk,
  input wire logic i_sdo,
  output logic o_sel_b,
  output logic o_sclk,
  output logic o_sdi
);
  initial begin
    o_sel_b = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic sel();
    gap(1);
    o_sel_b = 1'b0;
    gap(4);
  endtask
  // Deselect flips the host data output to the inverse of its last bit, not a stale value
  task automatic desel();
    gap(4);
    o_sel_b = 1'b1;
    o_sdi = ~o_sdi;
    gap(8);
  endtask
  // Output sampled late in the high phase, well after it has settled
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      o_sdi = tx[i];
      gap(4);
      o_sclk = 1'b1;
      gap(3);
      rx = {rx[6:0], i_sdo};
      gap(1);
      o_sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### test_serial_eeprom_access_sequencer.sv
// Self-checking bench of the access sequencer against the host model.
// Assumes all link stimulus changes on the falling edge of clk.
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_access_sequencer;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  logic sel_b, sclk, sdi, sdo, sdo_oe, busy, latch;
  logic [1:0] prot;
  logic [7:0] rx;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  // The host sees the inverse of the last bit whenever the device lets go of the line
  wire logic sdo_line = sdo_oe ? sdo : ~sdo;
  sepr_host h (.i_clk(clk), .i_sdo(sdo_line), .o_sel_b(sel_b), .o_sclk(sclk), .o_sdi(sdi));
  // Long enough that a status read and a rejected read fit inside one cycle
  sepr_sequencer #(.PROG_CYC(400)) DUT (.i_clk(clk), .i_rst_b(rst_b), .i_sel_b(sel_b), .i_sclk(sclk),
    .i_sdi(sdi), .i_wp_b(wp_b), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_busy(busy), .o_latch(latch), .o_protect(prot));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic one(input logic [7:0] c);
    h.sel();
    h.bits(c, 8, rx);
    h.desel();
  endtask
  task automatic hdr(input logic [7:0] c, input logic [7:0] a);
    h.sel();
    h.bits(c, 8, rx);
    h.bits(a, 8, rx);
  endtask
  task automatic rd2(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1);
    hdr({4'h0, a[8], 3'h3}, a[7:0]);
    h.bits(8'h00, 8, rx);
    cmp(rx, e0);
    h.bits(8'h00, 8, rx);
    cmp(rx, e1);
    h.desel();
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input int n);
    hdr({4'h0, a[8], 3'h2}, a[7:0]);
    for (int i = 0; i < n; i++) h.bits(d + i[7:0], 8, rx);
    h.desel();
  endtask
  task automatic stw(input logic [7:0] d, input int x);
    one(8'h06);
    hdr(8'h01, d);
    h.bits(8'h00, x, rx);
    h.desel();
  endtask
  task automatic srd(input logic [7:0] e);
    hdr(8'h05, 8'h00);
    cmp(rx, e);
    h.desel();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 500 && busy !== 1'b0; i++) @(negedge clk);
    cmp({7'h00, busy}, 8'h00);
  endtask
  task automatic t_reset();
    cmp({5'h00, busy, latch, sdo_oe}, 8'h00);
    cmp({6'h00, prot}, 8'h00);
    rd2(9'h005, 8'hff, 8'hff);
    $display("reset test done");
  endtask
  task automatic t_page();
    one(8'h06);
    cmp({7'h00, latch}, 8'h01);
    one(8'h04);
    cmp({7'h00, latch}, 8'h00);
    one(8'h06);
    wr(9'h1ff, 8'h40, 17);
    cmp({7'h00, busy}, 8'h01);
    srd(8'h03);
    hdr(8'h0b, 8'hfe);
    h.bits(8'h00, 8, rx);
    cmp({7'h00, sdo_oe}, 8'h00);
    h.desel();
    wait_idle();
    cmp({7'h00, latch}, 8'h00);
    rd2(9'h1fe, 8'h4f, 8'h50);
    rd2(9'h1ff, 8'h50, 8'hff);
    $display("page test done");
  endtask
  task automatic t_refuse();
    wr(9'h010, 8'h00, 1);
    cmp({7'h00, busy}, 8'h00);
    one(8'h06);
    wp_b = 1'b0;
    h.gap(6);
    cmp({7'h00, latch}, 8'h00);
    wp_b = 1'b1;
    one(8'h06);
    hdr(8'h02, 8'h10);
    h.bits(8'h00, 8, rx);
    h.bits(8'h00, 3, rx);
    h.desel();
    cmp({7'h00, busy}, 8'h00);
    rd2(9'h010, 8'hff, 8'hff);
    $display("refuse test done");
  endtask
  task automatic t_status();
    stw(8'h08, 1);
    cmp({6'h00, prot, busy}, 8'h00);
    stw(8'h04, 0);
    cmp({7'h00, busy}, 8'h01);
    wait_idle();
    cmp({6'h00, prot}, 8'h01);
    one(8'h06);
    wr(9'h180, 8'h00, 1);
    cmp({7'h00, busy}, 8'h00);
    rd2(9'h180, 8'hff, 8'hff);
    one(8'h06);
    wr(9'h17f, 8'h00, 1);
    cmp({7'h00, busy}, 8'h01);
    wait_idle();
    rd2(9'h17f, 8'h00, 8'hff);
    srd(8'h04);
    $display("status test done");
  endtask
  // Second reset with the latch set and protection at upper quarter
  task automatic t_rerun();
    one(8'h06);
    rst_b = 1'b0;
    h.gap(3);
    cmp({5'h00, busy, latch, sdo_oe}, 8'h00);
    rst_b = 1'b1;
    h.gap(4);
    cmp({6'h00, prot}, 8'h01);
    srd(8'h04);
    rd2(9'h17f, 8'h00, 8'hff);
    $display("reset rerun test done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_page();
    t_refuse();
    t_status();
    t_rerun();
    conclude();
  end
endmodule
bind sepr_sequencer sepr_chk #(.PROG_CYC(PROG_CYC)) u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sel_b(i_sel_b),
  .i_sclk(i_sclk), .i_sdi(i_sdi), .i_wp_b(i_wp_b), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_busy(o_busy),
  .o_latch(o_latch), .o_protect(o_protect));
`default_nettype wire
